/* common/wdr_map.vh */
`ifndef WDR_MAP_VH
`define WDR_MAP_VH
// register byte offsets
`define WDR_CTRL_OFF 12'h000
`define WDR_STAT_OFF 12'h004
`define WDR_MASK_OFF 12'h008
`define WDR_FLAG_OFF 12'h00c
// control register fields
`define WDR_EN_BIT 0
`define WDR_PS_LSB 1
`define WDR_PS_MSB 5
`define WDR_PS_RST 5'h0b
`define WDR_PS_MAX 5'h12
`define WDR_PS_BASE 5
// mode configuration encodings
`define WDR_MODE_OFF 2'h0
`define WDR_MODE_SW 2'h1
`define WDR_MODE_NOSLP 2'h2
`define WDR_MODE_ON 2'h3
// interrupt status bits
`define WDR_IRQ_RST 0
`define WDR_IRQ_WAKE 1
`define WDR_IRQ_W 2
// reset pulse length in mclk cycles
`define WDR_RST_CYC 4'h4
`endif

/* tb/test_watchdog_timer_reset.sv */
`timescale 1ns/1ps
module test_watchdog_timer_reset;
  // bench drives every input
  reg mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  reg sleep_mode = 0, watchdog_clear_instr = 0, osc_fail = 0;
  reg crystal_clock = 0, osc_startup_timer = 0;
  reg [3:0] intosc_divider_sel = 4'h5;
  reg [1:0] watchdog_mode_cfg = 2'h0;
  reg [2:0] ph = 3'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, wdt_reset_req, wdt_wake_req, timeout_flag_n, powerdown_flag_n, irq;
  wire low_freq_osc = ph[2];
  integer bad_count = 0, n_tests = 0, n;
  wdr_watchdog dut_u (.*);
  initial forever #12.5 mclk = ~mclk;
  // eight mclk per tick keeps periods short
  always @(posedge mclk) ph <= ph + 3'h1;
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    conclude;
  end
  task chk(input [31:0] got, input [31:0] exp, input string s);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("Error %s exp %h got %h", s, exp, got);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // ticks to the first event, t of zero means none
  task meas(input [1:0] m, input [31:0] c, input s, input integer t);
    apb(1, 12'h000, c);
    watchdog_mode_cfg <= m;
    watchdog_clear_instr <= 1;
    repeat (8) @(posedge mclk);
    sleep_mode <= s;
    watchdog_clear_instr <= 0;
    n = 0;
    while (!(wdt_reset_req | wdt_wake_req) && n < 1500) begin
      @(posedge mclk);
      n = n + 1;
    end
    chk(t ? (n > t * 8 - 8 && n < t * 8 + 16) : n == 1500, 1, "span");
    repeat (2) @(posedge mclk);
    sleep_mode <= 0;
  endtask
  task t_regs;
    apb(0, 12'h000, 0);
    chk(rd, 32'h16, "ctrl");
    apb(0, 12'h00c, 0);
    chk(rd[4:3], 2'h3, "flags");
    apb(1, 12'h000, 32'hffffffff);
    apb(0, 12'h000, 0);
    chk(rd, 32'h3f, "ctrl");
    apb(1, 12'h010, 32'h1);
    chk(er, 1, "slverr");
  endtask
  task t_periods;
    meas(2'h3, 32'h00, 0, 32);
    chk({timeout_flag_n, powerdown_flag_n}, 2'h1, "flags");
    meas(2'h3, 32'h02, 0, 64);
    meas(2'h3, 32'h26, 0, 32);
    meas(2'h3, 32'h3e, 0, 32);
  endtask
  task t_modes;
    meas(2'h3, 32'h0, 1, 32);
    chk({timeout_flag_n, powerdown_flag_n}, 2'h0, "flags");
    meas(2'h2, 32'h0, 1, 0);
    meas(2'h1, 32'h0, 0, 0);
    meas(2'h1, 32'h1, 1, 32);
    meas(2'h0, 32'h1, 0, 0);
    osc_fail <= 1;
    meas(2'h3, 32'h0, 0, 0);
    osc_fail <= 0;
  endtask
  task t_irq;
    apb(0, 12'h004, 0);
    chk(rd, 32'h3, "status");
    apb(1, 12'h008, 32'h2);
    repeat (2) @(negedge mclk);
    chk(irq, 1, "irq");
    apb(1, 12'h004, 32'h3);
    repeat (2) @(negedge mclk);
    chk(irq, 0, "irq");
  endtask
  task conclude;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    t_regs;
    t_periods;
    t_modes;
    t_irq;
    conclude;
  end
endmodule

/* tb/wdr_watchdog_sva.sv */
`timescale 1ns/1ps
module wdr_watchdog_sva (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // bus
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // watchdog
  input wire [1:0] watchdog_mode_cfg,
  input wire watchdog_clear_instr,
  input wire wdt_reset_req,
  input wire wdt_wake_req,
  input wire timeout_flag_n,
  input wire powerdown_flag_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_rst_pulse_len: assert property (
    $rose(wdt_reset_req) |-> wdt_reset_req[*4] ##1 !wdt_reset_req) else $error("rst pulse");
  a_rst_flags: assert property (
    $rose(wdt_reset_req) |-> ##[0:1] (!timeout_flag_n && powerdown_flag_n)) else $error("rst flags");
  a_wake_pulse: assert property (
    wdt_wake_req |=> !wdt_wake_req) else $error("wake pulse");
  a_wake_flags: assert property (
    $rose(wdt_wake_req) |-> ##[0:1] (!timeout_flag_n && !powerdown_flag_n)) else $error("wake flags");
  a_off_no_rst: assert property (
    (watchdog_mode_cfg == 2'h0)[*8] |-> !$rose(wdt_reset_req)) else $error("rst while off");
  a_clr_holds: assert property (
    watchdog_clear_instr[*8] |-> !$rose(wdt_reset_req)) else $error("rst while clear");
  a_apb_answer: assert property (
    psel && !penable |=> pready) else $error("no ready");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("lone slverr");
endmodule
bind wdr_watchdog wdr_watchdog_sva u_sva (.*);

/* verilog/wdr_watchdog.v */
`timescale 1ns/1ps
`include "wdr_map.vh"

// Functional notes
// - timeout while awake and active requests reset
// - counter runs on low frequency oscillator
// - mode 11 always active, sleep too
// - mode 10 active awake, off in sleep
// - mode 01 follows software enable bit
// - mode 00 off, enable ignored
// - prescale is two to code plus five
// - codes 10011 upward act as 1:32
// - reset gives period 01011, enable zero
// - clear on reset, instr, sleep, fail, disable
// - sleep entry clears, then counting resumes
// - wake clears; crystal waits startup timer
// - sleep timeout wakes, updates status flags
// - divider changes leave counter alone
// - enable bit0, period bits5-1, 7-6 zero
module wdr_watchdog (
  // system
  input wire mclk,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // device status and configuration (asynchronous to mclk)
  input wire low_freq_osc,
  input wire [1:0] watchdog_mode_cfg,
  input wire sleep_mode,
  input wire watchdog_clear_instr,
  input wire osc_fail,
  input wire crystal_clock,
  input wire osc_startup_timer,
  input wire [3:0] intosc_divider_sel,
  // results
  output reg wdt_reset_req,
  output reg wdt_wake_req,
  output reg timeout_flag_n,
  output reg powerdown_flag_n,
  output reg irq
);

  // synchroniser stages, first flop read only by second
  reg [8:0] s1_q;
  reg [8:0] s2_q;
  reg osc_d1_q;
  reg sleep_d1_q;
  reg [22:0] cnt_q;
  reg [4:0] ps_q;
  reg en_q;
  reg [1:0] stat_q;
  reg [1:0] mask_q;
  reg [3:0] rst_cnt_q;
  reg hold_q;

  wire osc_s = s2_q[0];
  wire [1:0] mode_s = s2_q[2:1];
  wire sleep_s = s2_q[3];
  wire clr_s = s2_q[4];
  wire fail_s = s2_q[5];
  wire xtal_s = s2_q[6];
  wire ost_s = s2_q[7];

  // synchronise every status pin except divider select, which is intentionally never read
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
    end else begin
      s1_q <= {1'b0, osc_startup_timer, crystal_clock, osc_fail, watchdog_clear_instr,
               sleep_mode, watchdog_mode_cfg, low_freq_osc};
      s2_q <= s1_q;
    end
  end

  // terminal count for a period code, reserved codes fold to 1:32
  function [22:0] wdr_limit;
    input [4:0] code;
    begin
      if (code > `WDR_PS_MAX)
        wdr_limit = 23'h00001f;
      else
        wdr_limit = (23'h000001 << (code + `WDR_PS_BASE)) - 23'h000001;
    end
  endfunction

  // mode table decides whether the counter may run
  reg active;
  always @* begin
    case (mode_s)
      `WDR_MODE_ON: active = 1'b1;
      `WDR_MODE_NOSLP: active = ~sleep_s;
      `WDR_MODE_SW: active = en_q;
      `WDR_MODE_OFF: active = 1'b0;
      default: active = 1'b0;
    endcase
  end

  wire osc_tick = osc_s & ~osc_d1_q;
  wire slp_edge = sleep_s ^ sleep_d1_q;
  wire wake_hold = hold_q | (sleep_d1_q & ~sleep_s & xtal_s);
  // clears need no oscillator edge, so they act at once on mclk
  wire clear = ~active | clr_s | fail_s | slp_edge | (wake_hold & ost_s);
  // a clear in the same cycle as the terminal tick must win, or a late clear still resets
  wire expire = osc_tick & ~clear & (cnt_q == wdr_limit(ps_q));
  wire wr = psel & penable & pwrite;
  wire [1:0] ev = {expire & sleep_s, expire & ~sleep_s};

  // watchdog counter
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 23'h000000;
      osc_d1_q <= 1'b0;
      sleep_d1_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      osc_d1_q <= osc_s;
      sleep_d1_q <= sleep_s;
      // crystal wake waits until the startup timer stops running
      hold_q <= wake_hold & ost_s;
      if (clear)
        cnt_q <= 23'h000000;
      else if (expire)
        cnt_q <= 23'h000000;
      else if (osc_tick)
        cnt_q <= cnt_q + 23'h000001;
    end
  end

  // reset pulse, wake pulse and status flags
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_q <= 4'h0;
      wdt_reset_req <= 1'b0;
      wdt_wake_req <= 1'b0;
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else begin
      if (ev[0])
        rst_cnt_q <= `WDR_RST_CYC;
      else if (rst_cnt_q != 4'h0)
        rst_cnt_q <= rst_cnt_q - 4'h1;
      wdt_reset_req <= ev[0] | (rst_cnt_q > 4'h1);
      wdt_wake_req <= ev[1];
      if (ev[1]) begin
        timeout_flag_n <= 1'b0;
        powerdown_flag_n <= 1'b0;
      end else if (ev[0]) begin
        timeout_flag_n <= 1'b0;
        powerdown_flag_n <= 1'b1;
      end else if (sleep_s & ~sleep_d1_q) begin
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b0;
      end else if (clr_s) begin
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
    end
  end

  // registers: software bits; status set wins over write-one clear
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ps_q <= `WDR_PS_RST;
      en_q <= 1'b0;
      mask_q <= 2'h0;
      stat_q <= 2'h0;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == `WDR_CTRL_OFF) begin
        ps_q <= pwdata[`WDR_PS_MSB:`WDR_PS_LSB];
        en_q <= pwdata[`WDR_EN_BIT];
      end
      if (wr && paddr == `WDR_MASK_OFF)
        mask_q <= pwdata[1:0];
      if (wr && paddr == `WDR_STAT_OFF)
        stat_q <= (stat_q & ~pwdata[1:0]) | ev;
      else
        stat_q <= stat_q | ev;
      irq <= |(stat_q & mask_q);
    end
  end

  // apb answer: no wait state, unmapped address raises pslverr
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != `WDR_CTRL_OFF) & (paddr != `WDR_STAT_OFF)
                 & (paddr != `WDR_MASK_OFF) & (paddr != `WDR_FLAG_OFF);
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `WDR_CTRL_OFF: prdata <= {26'h0000000, ps_q, en_q};
          `WDR_STAT_OFF: prdata <= {30'h00000000, stat_q};
          `WDR_MASK_OFF: prdata <= {30'h00000000, mask_q};
          `WDR_FLAG_OFF: prdata <= {27'h0000000, powerdown_flag_n, timeout_flag_n, active,
                                    mode_s};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
